//--- amrf_defs.vh
/*
 Constants for the converter selection and result formatting block:
 register indices, field positions, reset values and code bounds.
 Assumes inclusion by bare name from the design file.
*/
`ifndef AMRF_DEFS_VH
`define AMRF_DEFS_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define AMRF_ADDR_SEL      4'h0
`define AMRF_ADDR_RES_LO   4'h1
`define AMRF_ADDR_RES_HI   4'h2
`define AMRF_ADDR_STATUS   4'h3
`define AMRF_ADDR_ACTIVE   4'h4

// ----------------------------------------------------------------
// Selection register fields
// ----------------------------------------------------------------
`define AMRF_SEL_RESET     8'h00
`define AMRF_REF_HI        7
`define AMRF_REF_LO        6
`define AMRF_LJ_BIT        5
`define AMRF_CH_HI         4
`define AMRF_CH_LO         0

// ----------------------------------------------------------------
// Reference codes
// ----------------------------------------------------------------
`define AMRF_REF_EXT_PIN   2'h0
`define AMRF_REF_SUPPLY    2'h1
`define AMRF_REF_RESERVED  2'h2
`define AMRF_REF_INT_256   2'h3

// ----------------------------------------------------------------
// Status bits and code bounds
// ----------------------------------------------------------------
`define AMRF_ST_DONE       0
`define AMRF_ST_BUSY       1
`define AMRF_ST_DIFF       2
`define AMRF_SE_MIN        10'h000
`define AMRF_SE_MAX        10'h3ff
`define AMRF_DIFF_MIN      10'h200
`define AMRF_DIFF_MAX      10'h1ff
`define AMRF_CH_SE_LAST    5'h07
`define AMRF_CH_BANDGAP    5'h1e
`define AMRF_CH_GROUND     5'h1f

`endif

//--- amrf_top.v
/*
 Selection register, conversion latching and result formatting for a
 10-bit successive-approximation converter.
 Assumes the analog core takes the latched reference and channel at
 conv_start and returns a raw 10-bit code with a one-cycle conv_end.
*/
// The strobed register port and the address map were chosen for this implementation.
`default_nettype none
`include "amrf_defs.vh"

// ----------------------------------------------------------------
// Top module
// ----------------------------------------------------------------
module amrf_top (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Register port
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_en,
  input  wire       rd_en,
  output reg  [7:0] rdata,
  // Conversion control
  input  wire       conv_start,
  input  wire       conv_end,
  input  wire [9:0] conv_raw,
  // Analog core selection
  output reg  [1:0] reference_select_active,
  output reg  [4:0] channel_select_active,
  output wire       ref_external_pin_en,
  output wire       ref_analog_supply_en,
  output wire       ref_internal_en,
  output wire       conv_busy
);

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Channel codes 0-7 and 30-31 are single-ended, the rest differential
  function is_diff;
    input [4:0] ch;
    begin
      is_diff = (ch > `AMRF_CH_SE_LAST) && (ch < `AMRF_CH_BANDGAP);
    end
  endfunction

  // One address compare shared by both write strobes; the read port decodes addr in its own case
  function reg_hit;
    input [3:0] a;
    input [3:0] idx;
    begin
      reg_hit = (a == idx);
    end
  endfunction

  function [1:0] ref_field;
    input [7:0] sel;
    begin
      ref_field = sel[`AMRF_REF_HI:`AMRF_REF_LO];
    end
  endfunction

  function [4:0] ch_field;
    input [7:0] sel;
    begin
      ch_field = sel[`AMRF_CH_HI:`AMRF_CH_LO];
    end
  endfunction

  // Enable bit index to reference code; the reserved code has no bit
  function [1:0] ref_code;
    input integer idx;
    begin
      case (idx)
        0: begin
          ref_code = `AMRF_REF_EXT_PIN;
        end
        1: begin
          ref_code = `AMRF_REF_SUPPLY;
        end
        default: begin
          ref_code = `AMRF_REF_INT_256;
        end
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  localparam NUM_REF_EN = 3;

  reg  [7:0]            sel_reg;
  reg  [7:0]            sel_next;
  reg  [1:0]            ref_act_next;
  reg  [4:0]            ch_act_next;
  reg                   busy_reg;
  reg                   busy_next;
  reg                   diff_reg;
  reg                   diff_next;
  reg  [9:0]            result_reg;
  reg  [9:0]            result_next;
  reg                   done_reg;
  reg                   done_next;
  reg  [7:0]            rdata_next;
  wire                  lj;
  wire                  sel_wr;
  wire                  status_wr;
  wire                  accept_start;
  wire                  accept_end;
  wire [NUM_REF_EN-1:0] ref_en;
  wire [15:0]           pair_right;
  wire [15:0]           pair_left;
  wire [15:0]           pair;
  wire [7:0]            lo_byte;
  wire [7:0]            hi_byte;

  // --------------------------------------------------------------
  // Strobes and events
  // --------------------------------------------------------------
  assign lj           = sel_reg[`AMRF_LJ_BIT];
  assign sel_wr       = wr_en && reg_hit(addr, `AMRF_ADDR_SEL);
  assign status_wr    = wr_en && reg_hit(addr, `AMRF_ADDR_STATUS);
  // Start while busy and end while idle are both ignored
  assign accept_start = conv_start && !busy_reg;
  assign accept_end   = conv_end && busy_reg;
  assign conv_busy    = busy_reg;

  // --------------------------------------------------------------
  // Selection register
  // --------------------------------------------------------------
  always @* begin
    sel_next = sel_reg;
    if (sel_wr) begin
      sel_next = wdata;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      sel_reg <= `AMRF_SEL_RESET;
    end else begin
      sel_reg <= sel_next;
    end
  end

  // --------------------------------------------------------------
  // Conversion tracking and active selection
  // --------------------------------------------------------------
  always @* begin
    busy_next = busy_reg;
    if (accept_start) begin
      busy_next = 1'b1;
    end else if (accept_end) begin
      busy_next = 1'b0;
    end
  end

  // Kind of the running channel, kept for the status word
  always @* begin
    diff_next = diff_reg;
    if (accept_start) begin
      diff_next = is_diff(ch_field(sel_reg));
    end
  end

  // The core only ever sees settings frozen at start, so software
  // writes during a conversion cannot disturb it
  always @* begin
    ref_act_next = reference_select_active;
    ch_act_next  = channel_select_active;
    if (!busy_reg || accept_end) begin
      // Idle selection follows the register
      ref_act_next = ref_field(sel_reg);
      ch_act_next  = ch_field(sel_reg);
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reference_select_active <= `AMRF_REF_EXT_PIN;
      channel_select_active   <= 5'h00;
      busy_reg                <= 1'b0;
      diff_reg                <= 1'b0;
    end else begin
      reference_select_active <= ref_act_next;
      channel_select_active   <= ch_act_next;
      busy_reg                <= busy_next;
      diff_reg                <= diff_next;
    end
  end

  // --------------------------------------------------------------
  // Reference enables
  // --------------------------------------------------------------
  // Reserved code enables no reference at all
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REF_EN; gi = gi + 1) begin : g_ref_en
      assign ref_en[gi] = (reference_select_active == ref_code(gi));
    end
  endgenerate

  assign ref_external_pin_en  = ref_en[0];
  assign ref_analog_supply_en = ref_en[1];
  assign ref_internal_en      = ref_en[2];

  // --------------------------------------------------------------
  // Result capture and done flag
  // --------------------------------------------------------------
  // Raw code is stored as-is: unsigned for single-ended, two's
  // complement for differential, so bit 9 is the sign there
  always @* begin
    result_next = result_reg;
    if (accept_end) begin
      result_next = conv_raw;
    end
  end

  // Set beats a same-cycle clear-by-one
  always @* begin
    done_next = done_reg;
    if (accept_end) begin
      done_next = 1'b1;
    end else if (status_wr && wdata[`AMRF_ST_DONE]) begin
      done_next = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      result_reg <= `AMRF_SE_MIN;
      done_reg   <= 1'b0;
    end else begin
      result_reg <= result_next;
      done_reg   <= done_next;
    end
  end

  // --------------------------------------------------------------
  // Presentation
  // --------------------------------------------------------------
  // Combinational on the justify bit, so a flip shows at once
  assign pair_right = {6'h00, result_reg};
  assign pair_left  = {result_reg, 6'h00};
  assign pair       = lj ? pair_left : pair_right;
  assign lo_byte    = pair[7:0];
  assign hi_byte    = pair[15:8];

  // --------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------
  always @* begin
    rdata_next = 8'h00;
    if (rd_en) begin
      case (addr)
        `AMRF_ADDR_SEL: begin
          rdata_next = sel_reg;
        end
        `AMRF_ADDR_RES_LO: begin
          rdata_next = lo_byte;
        end
        `AMRF_ADDR_RES_HI: begin
          rdata_next = hi_byte;
        end
        `AMRF_ADDR_STATUS: begin
          rdata_next[`AMRF_ST_DONE] = done_reg;
          rdata_next[`AMRF_ST_BUSY] = busy_reg;
          rdata_next[`AMRF_ST_DIFF] = diff_reg;
        end
        `AMRF_ADDR_ACTIVE: begin
          rdata_next = {reference_select_active, 1'b0,
                        channel_select_active};
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // Read data stands for one cycle only, zero otherwise
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_next;
    end
  end

endmodule // amrf_top
`default_nettype wire

//--- amrf_core_model.sv
/* Analog core stand-in: ends a conversion lat cycles after start.
 Assumes the bench drives start, lat and code from clk. */
`default_nettype none
module amrf_core_model (
  // Clock, reset and control
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       busy,
  input  wire logic [3:0] lat,
  input  wire logic [9:0] code,
  // Result
  output logic            conv_end,
  output logic [9:0]      conv_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  always_ff @(posedge clk) begin
    conv_end <= 1'b0;
    // Garbage outside the end pulse
    conv_raw <= ~conv_raw;
    if (rst) begin
      cnt_reg  <= 4'h0;
      conv_raw <= 10'h155;
    end else if (start && !busy) begin
      cnt_reg <= lat;
    end else if (cnt_reg == 4'h1) begin
      cnt_reg  <= 4'h0;
      conv_end <= 1'b1;
      conv_raw <= code;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule // amrf_core_model
`default_nettype wire

//--- amrf_chk.sv
/* Port checker for amrf_top.
 Assumes binding by name to each amrf_top instance. */
`default_nettype none
module amrf_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Register port
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  // Conversion control
  input wire logic       conv_start,
  input wire logic       conv_end,
  input wire logic       conv_busy,
  // Analog core selection
  input wire logic [1:0] reference_select_active,
  input wire logic [4:0] channel_select_active,
  input wire logic       ref_external_pin_en,
  input wire logic       ref_analog_supply_en,
  input wire logic       ref_internal_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_BUSY_SET: assert property (conv_start && !conv_busy |=> conv_busy)
    else $error("busy not set");
  AST_BUSY_END: assert property (conv_end && conv_busy |=> !conv_busy)
    else $error("busy not cleared");
  AST_REF_HOLD: assert property (conv_busy ##1 conv_busy
    |-> $stable(reference_select_active)) else $error("ref moved");
  AST_CH_HOLD: assert property (conv_busy ##1 conv_busy
    |-> $stable(channel_select_active)) else $error("channel moved");
  AST_EXT_DEC: assert property (ref_external_pin_en ==
    (reference_select_active == 2'h0)) else $error("ext decode");
  AST_INT_DEC: assert property (ref_internal_en ==
    (reference_select_active == 2'h3)) else $error("int decode");
  AST_RESERVED: assert property (reference_select_active == 2'h2
    |-> !ref_analog_supply_en && !ref_external_pin_en)
    else $error("reserved decode");
  AST_RD_IDLE: assert property (!rd_en |=> rdata == 8'h00)
    else $error("rdata not idle");
  cover property (conv_end && conv_busy);
  cover property (conv_busy ##1 !conv_busy);
  cover property (rd_en);
endmodule // amrf_chk
bind amrf_top amrf_chk u_chk (
  .clk                     (clk),
  .rst                     (rst),
  .rd_en                   (rd_en),
  .rdata                   (rdata),
  .conv_start              (conv_start),
  .conv_end                (conv_end),
  .conv_busy               (conv_busy),
  .reference_select_active (reference_select_active),
  .channel_select_active   (channel_select_active),
  .ref_external_pin_en     (ref_external_pin_en),
  .ref_analog_supply_en    (ref_analog_supply_en),
  .ref_internal_en         (ref_internal_en)
);
`default_nettype wire

//--- testbench.sv
/* Bench for amrf_top: register reset, conversions and layout.
 Assumes amrf_top, the core model and the checker are compiled. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, conv_start = 0;
  logic [3:0] addr = 4'h0, lat = 4'h1;
  logic [7:0] wdata = 8'h00;
  logic [9:0] code = 10'h000;
  wire logic [7:0] rdata;
  wire logic [9:0] raw;
  wire logic [4:0] ch;
  wire logic [1:0] rs;
  wire logic ce, ext, sup, ri, busy;
  int checks = 0, bad_count = 0, cyc = 0;
  amrf_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .conv_start(conv_start),
    .conv_end(ce), .conv_raw(raw), .reference_select_active(rs),
    .channel_select_active(ch), .ref_external_pin_en(ext),
    .ref_analog_supply_en(sup), .ref_internal_en(ri), .conv_busy(busy));
  amrf_core_model core (.clk(clk), .rst(rst), .start(conv_start),
    .busy(busy), .lat(lat), .code(code), .conv_end(ce), .conv_raw(raw));
  task automatic complete_run;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic go(input logic [3:0] l, input logic [9:0] c);
    @(posedge clk);
    lat        <= l;
    code       <= c;
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
  endtask
  task automatic wt;
    @(posedge clk);
    repeat (30) if (busy === 1'b1) @(posedge clk);
  endtask
  // Layout: left puts code on top of 16 bits, right at the bottom
  function automatic logic [15:0] lay(input logic lj, input logic [9:0] c);
    return lj ? {c, 6'h00} : {6'h00, c};
  endfunction
  task automatic res(input logic [7:0] s, input logic [9:0] c);
    logic d;
    logic [15:0] v;
    d = s[4:0] >= 5'h08 && s[4:0] <= 5'h1d;
    wr(4'h0, s);
    rd(4'h0, s);
    go(4'h1, c);
    wt;
    rd(4'h3, {5'h00, d, 2'b01});
    for (int k = 0; k < 2; k++) begin
      v = lay(s[5] ^ k[0], c);
      wr(4'h0, s ^ {2'b00, k[0], 5'h00});
      rd(4'h1, v[7:0]);
      rd(4'h2, v[15:8]);
    end
    wr(4'h3, 8'h01);
    rd(4'h3, {5'h00, d, 2'b00});
    $display("test result %h done", s);
  endtask
  task automatic t_reset;
    for (int a = 0; a < 6; a++) rd(a[3:0], 8'h00);
    rd(4'hf, 8'h00);
    chk({5'h00, ext, sup, ri}, 8'h04);
    $display("test reset done");
  endtask
  task automatic t_freeze;
    wr(4'h0, 8'hc3);
    go(4'h8, 10'h155);
    wr(4'h0, 8'h49);
    rd(4'h4, 8'hc3);
    chk({5'h00, ext, sup, ri}, 8'h01);
    chk({rs, 1'b0, ch}, 8'hc3);
    wt;
    rd(4'h4, 8'h49);
    chk({5'h00, ext, sup, ri}, 8'h02);
    wr(4'h0, 8'h80);
    rd(4'h4, 8'h80);
    chk({5'h00, ext, sup, ri}, 8'h00);
    $display("test freeze done");
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    res(8'hed, 10'h270);
    res(8'hfb, 10'h029);
    res(8'h40, 10'h3ff);
    res(8'h00, 10'h000);
    t_freeze;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
